// >>> hdl/acpu_cfg.svh
// constants of the accumulator core: field positions, offsets, resets, counts
`ifndef ACPU_CFG_SVH
`define ACPU_CFG_SVH
`define ACPU_PC_W      11
`define ACPU_OP_HI     15
`define ACPU_OP_LO     11
`define ACPU_ICYC      2'h3
`define ACPU_IVEC      11'h004
`define ACPU_PC_RST    11'h000
`define ACPU_RUN_RST   1'b1
`define ACPU_CTRL_OFF  4'h0
`define ACPU_STAT_OFF  4'h4
`define ACPU_PCR_OFF   4'h8
`define ACPU_CTRL_RUN  0
`define ACPU_STAT_C    8
`define ACPU_STAT_NIB  9
`define ACPU_STAT_Z    10
`define ACPU_STAT_WRAP 11
`define ACPU_STAT_GIE  12
`define ACPU_RESP_OKAY 2'h0
`define ACPU_RESP_SLV  2'h2
`endif

// >>> hdl/acpu_pkg.sv
// types of the accumulator core: opcodes, sequencer states, state record
package acpu_pkg;
`include "acpu_cfg.svh"
  typedef enum logic [4:0] {
    OP_IDLE, OP_JUMP, OP_LD_M, OP_LD_I, OP_ST_M, OP_OR_M, OP_OR_I, OP_OR_TO_M,
    OP_SUB_EXIT, OP_SUB_EXIT_I, OP_IRQ_EXIT, OP_ROTL_M, OP_ROTL_A, OP_ROTLC_M,
    OP_ROTLC_A, OP_ROTR_M, OP_ROTR_A, OP_ROTRC_M, OP_ROTRC_A, OP_SUBB_A,
    OP_SUBB_M, OP_DEC_SKZ
  } acpu_op_t;

  typedef enum logic [1:0] {ST_FETCH, ST_DECODE, ST_EXEC, ST_DUMMY} acpu_st_t;

  typedef struct packed {
    acpu_st_t              st;
    logic [1:0]            cnt;
    logic [`ACPU_PC_W-1:0] pc;
    logic [15:0]           ir;
    logic [7:0]            acc;
    logic                  c;
    logic                  nib;
    logic                  z;
    logic                  wrap;
    logic                  gie;
    logic                  run;
    logic [`ACPU_PC_W-1:0] pm_addr;
    logic [7:0]            dm_addr;
    logic [7:0]            dm_wdata;
    logic                  dm_we;
    logic                  stk_pop;
    logic                  stk_push;
    logic [`ACPU_PC_W-1:0] stk_wdata;
    logic                  awready;
    logic                  wready;
    logic                  aw_got;
    logic                  w_got;
    logic [3:0]            awaddr;
    logic [31:0]           wdata;
    logic                  wstrb0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } acpu_state_t;
endpackage

// >>> hdl/acpu_alu.sv
// byte datapath of the accumulator core: logic, rotates, subtract, decrement
`timescale 1ns/1ps
`default_nettype none
module acpu_alu
  import acpu_pkg::*;
(
  input  wire acpu_op_t   op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] m,
  input  wire logic       c_i,
  output logic [7:0]      res,
  output logic            c_o,
  output logic            nib_o,
  output logic            wrap_o
);
  logic [8:0] diff;
  logic [4:0] ldiff;

  always_comb begin
    diff   = {1'b0, a} - {1'b0, m} - {8'h00, ~c_i};
    ldiff  = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c_i};
    res    = m;
    c_o    = c_i;
    nib_o  = ldiff[4];
    wrap_o = (a[7] ^ m[7]) & (a[7] ^ diff[7]);
    case (op)
      OP_ST_M: res = a;
      OP_OR_M, OP_OR_I, OP_OR_TO_M: res = a | m;
      OP_ROTL_M, OP_ROTL_A: res = {m[6:0], m[7]};
      OP_ROTLC_M, OP_ROTLC_A: begin
        res = {m[6:0], c_i};
        c_o = m[7];
      end
      OP_ROTR_M, OP_ROTR_A: res = {m[0], m[7:1]};
      OP_ROTRC_M, OP_ROTRC_A: begin
        res = {c_i, m[7:1]};
        c_o = m[0];
      end
      OP_SUBB_A, OP_SUBB_M: begin
        res = diff[7:0];
        c_o = ~diff[8];
      end
      OP_DEC_SKZ: res = m - 8'h01;
      default: res = m;
    endcase
  end
endmodule
`default_nettype wire

// >>> hdl/acpu_core.sv
// accumulator core sequencer with its axi4-lite control and status port
`timescale 1ns/1ps
`default_nettype none
`include "acpu_cfg.svh"
module acpu_core
  import acpu_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  output logic [`ACPU_PC_W-1:0]      pm_addr,
  input  wire logic [15:0]           pm_rdata,
  output logic [7:0]                 dm_addr,
  input  wire logic [7:0]            dm_rdata,
  output logic [7:0]                 dm_wdata,
  output logic                       dm_we,
  input  wire logic [`ACPU_PC_W-1:0] stk_top,
  output logic                       stk_pop,
  output logic                       stk_push,
  output logic [`ACPU_PC_W-1:0]      stk_wdata,
  input  wire logic                  irq_req,
  input  wire logic [3:0]            awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [3:0]            araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready
);
  acpu_state_t s_q;
  acpu_state_t s_d;
  acpu_op_t    op;
  logic [7:0]  opnd;
  logic [7:0]  res;
  logic        alu_c;
  logic        alu_nib;
  logic        alu_wrap;
  logic        is_imm;
  logic        wr_mem;
  logic        to_acc;
  logic        pop;
  logic        dummy;
  logic [31:0] rd;

  // ---------------------------------------------------------------
  // operand select and datapath
  // ---------------------------------------------------------------
  assign op     = acpu_op_t'(s_q.ir[`ACPU_OP_HI:`ACPU_OP_LO]);
  assign is_imm = (op == OP_LD_I) || (op == OP_OR_I) || (op == OP_SUB_EXIT_I);
  assign opnd   = is_imm ? s_q.ir[7:0] : dm_rdata;

  acpu_alu u_alu (
    .op     (op),
    .a      (s_q.acc),
    .m      (opnd),
    .c_i    (s_q.c),
    .res    (res),
    .c_o    (alu_c),
    .nib_o  (alu_nib),
    .wrap_o (alu_wrap)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.dm_we    = 1'b0;
    s_d.stk_pop  = 1'b0;
    s_d.stk_push = 1'b0;
    wr_mem       = 1'b0;
    to_acc       = 1'b0;
    pop          = 1'b0;
    dummy        = 1'b0;
    rd           = 32'h00000000;

    case (s_q.st)
      ST_FETCH: begin
        if (s_q.run) begin
          // interrupts are taken only between instructions
          if (s_q.gie && irq_req) begin
            s_d.stk_push  = 1'b1;
            s_d.stk_wdata = s_q.pc;
            s_d.pc        = `ACPU_IVEC;
            s_d.gie       = 1'b0;
            s_d.cnt       = 2'h0;
            s_d.st        = ST_DUMMY;
          end else begin
            s_d.pm_addr = s_q.pc;
            s_d.st      = ST_DECODE;
          end
        end
      end
      ST_DECODE: begin
        s_d.ir      = pm_rdata;
        s_d.dm_addr = pm_rdata[7:0];
        s_d.pc      = s_q.pc + `ACPU_PC_W'(1);
        s_d.st      = ST_EXEC;
      end
      ST_EXEC: begin
        case (op)
          OP_JUMP: begin
            s_d.pc = s_q.ir[`ACPU_PC_W-1:0];
            dummy  = 1'b1;
          end
          OP_LD_M, OP_LD_I: to_acc = 1'b1;
          OP_ST_M: wr_mem = 1'b1;
          OP_OR_M, OP_OR_I: begin
            to_acc = 1'b1;
            s_d.z  = (res == 8'h00);
          end
          OP_OR_TO_M: begin
            wr_mem = 1'b1;
            s_d.z  = (res == 8'h00);
          end
          OP_SUB_EXIT: pop = 1'b1;
          OP_SUB_EXIT_I: begin
            pop    = 1'b1;
            to_acc = 1'b1;
          end
          OP_IRQ_EXIT: begin
            pop     = 1'b1;
            s_d.gie = 1'b1;
          end
          OP_ROTL_M, OP_ROTR_M: wr_mem = 1'b1;
          OP_ROTL_A, OP_ROTR_A: to_acc = 1'b1;
          OP_ROTLC_M, OP_ROTRC_M: begin
            wr_mem = 1'b1;
            s_d.c  = alu_c;
          end
          OP_ROTLC_A, OP_ROTRC_A: begin
            to_acc = 1'b1;
            s_d.c  = alu_c;
          end
          OP_SUBB_A, OP_SUBB_M: begin
            to_acc   = (op == OP_SUBB_A);
            wr_mem   = (op == OP_SUBB_M);
            s_d.c    = alu_c;
            s_d.nib  = alu_nib;
            s_d.wrap = alu_wrap;
            s_d.z    = (res == 8'h00);
          end
          OP_DEC_SKZ: begin
            wr_mem = 1'b1;
            if (res == 8'h00) begin
              s_d.pc = s_q.pc + `ACPU_PC_W'(1);
              dummy  = 1'b1;
            end
          end
          default: ;
        endcase
        if (to_acc) begin
          s_d.acc = res;
        end
        if (wr_mem) begin
          s_d.dm_we    = 1'b1;
          s_d.dm_wdata = res;
        end
        if (pop) begin
          s_d.pc      = stk_top;
          s_d.stk_pop = 1'b1;
        end
        s_d.cnt = 2'h0;
        s_d.st  = dummy ? ST_DUMMY : ST_FETCH;
      end
      ST_DUMMY: begin
        // one whole instruction cycle spent while the new address settles
        s_d.cnt = s_q.cnt + 2'h1;
        if (s_q.cnt == `ACPU_ICYC - 2'h1) begin
          s_d.st = ST_FETCH;
        end
      end
      default: s_d.st = ST_FETCH;
    endcase

    // -------------------------------------------------------------
    // axi4-lite write channel
    // -------------------------------------------------------------
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got  = 1'b1;
      s_d.wdata  = wdata;
      s_d.wstrb0 = wstrb[0];
    end
    if (bready && s_q.bvalid) begin
      s_d.bvalid = 1'b0;
    end
    if (s_d.aw_got && s_d.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = `ACPU_RESP_OKAY;
      if (s_d.awaddr == `ACPU_CTRL_OFF) begin
        if (s_d.wstrb0) begin
          s_d.run = s_d.wdata[`ACPU_CTRL_RUN];
        end
      end else if (s_d.awaddr == `ACPU_STAT_OFF || s_d.awaddr == `ACPU_PCR_OFF) begin
        s_d.bresp = `ACPU_RESP_OKAY;
      end else begin
        s_d.bresp = `ACPU_RESP_SLV;
      end
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;

    // -------------------------------------------------------------
    // axi4-lite read channel
    // -------------------------------------------------------------
    if (araddr == `ACPU_CTRL_OFF) begin
      rd[`ACPU_CTRL_RUN] = s_q.run;
    end else if (araddr == `ACPU_STAT_OFF) begin
      rd[7:0]             = s_q.acc;
      rd[`ACPU_STAT_C]    = s_q.c;
      rd[`ACPU_STAT_NIB]  = s_q.nib;
      rd[`ACPU_STAT_Z]    = s_q.z;
      rd[`ACPU_STAT_WRAP] = s_q.wrap;
      rd[`ACPU_STAT_GIE]  = s_q.gie;
    end else if (araddr == `ACPU_PCR_OFF) begin
      rd[`ACPU_PC_W-1:0] = s_q.pc;
    end
    if (rready && s_q.rvalid) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd;
      s_d.rresp  = (araddr == `ACPU_CTRL_OFF || araddr == `ACPU_STAT_OFF ||
                    araddr == `ACPU_PCR_OFF) ? `ACPU_RESP_OKAY : `ACPU_RESP_SLV;
    end
    s_d.arready = !s_d.rvalid;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q     <= '0;
      s_q.run <= `ACPU_RUN_RST;
      s_q.pc  <= `ACPU_PC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pm_addr   = s_q.pm_addr;
  assign dm_addr   = s_q.dm_addr;
  assign dm_wdata  = s_q.dm_wdata;
  assign dm_we     = s_q.dm_we;
  assign stk_pop   = s_q.stk_pop;
  assign stk_push  = s_q.stk_push;
  assign stk_wdata = s_q.stk_wdata;
  assign awready   = s_q.awready;
  assign wready    = s_q.wready;
  assign bvalid    = s_q.bvalid;
  assign bresp     = s_q.bresp;
  assign arready   = s_q.arready;
  assign rvalid    = s_q.rvalid;
  assign rresp     = s_q.rresp;
  assign rdata     = s_q.rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic ex;
  assign ex = (s_q.st == ST_EXEC);

  a_jump_dummy: assert property (
    ex && op == OP_JUMP |=> s_q.pc == $past(s_q.ir[`ACPU_PC_W-1:0])
      && s_q.st == ST_DUMMY [*3] ##1 s_q.st == ST_FETCH)
    else $error("jump target or dummy cycle wrong");
  a_load_mem: assert property (
    ex && op == OP_LD_M |=> s_q.acc == $past(dm_rdata) && $stable({s_q.c, s_q.z}))
    else $error("memory load wrong");
  a_load_imm: assert property (
    ex && op == OP_LD_I |=> s_q.acc == $past(s_q.ir[7:0]) && $stable(s_q.z))
    else $error("immediate load wrong");
  a_store_mem: assert property (
    ex && op == OP_ST_M |=> dm_we && dm_wdata == $past(s_q.acc) && $stable(s_q.acc))
    else $error("store wrong");
  a_idle_quiet: assert property (
    ex && op == OP_IDLE |=> !dm_we && $stable({s_q.acc, s_q.c, s_q.z}))
    else $error("idle changed state");
  a_or_zero: assert property (
    ex && op == OP_OR_I |=> s_q.z == (s_q.acc == 8'h00) && $stable(s_q.c))
    else $error("or zero flag wrong");
  a_exit_pop: assert property (
    ex && (op == OP_SUB_EXIT || op == OP_SUB_EXIT_I) |=> stk_pop
      && s_q.pc == $past(stk_top))
    else $error("exit did not pop");
  a_exit_gie: assert property (
    ex && op == OP_IRQ_EXIT |=> s_q.gie && stk_pop)
    else $error("interrupt exit enable missing");
  a_irq_serve: assert property (
    s_q.st == ST_FETCH && s_q.run && s_q.gie && irq_req |=> stk_push
      && s_q.pc == `ACPU_IVEC && !s_q.gie)
    else $error("pending interrupt not served");
  a_rot_accum: assert property (
    ex && op == OP_ROTL_A |=> !dm_we
      && s_q.acc == {$past(dm_rdata[6:0]), $past(dm_rdata[7])})
    else $error("rotate to accumulator wrong");
  a_subb_carry: assert property (
    ex && op == OP_SUBB_A |=> s_q.c == ({1'b0, $past(s_q.acc)} >=
      ($past({1'b0, dm_rdata}) + $past({8'h00, !s_q.c}))))
    else $error("borrow carry wrong");
  a_subb_mem: assert property (
    ex && op == OP_SUBB_M |=> dm_we && $stable(s_q.acc))
    else $error("subtract to memory wrong");
  a_dec_skip: assert property (
    ex && op == OP_DEC_SKZ && dm_rdata == 8'h01 |=> dm_we && dm_wdata == 8'h00
      && s_q.st == ST_DUMMY)
    else $error("decrement skip wrong");

  c_jump: cover property (ex && op == OP_JUMP);
  c_irq_after_exit: cover property (ex && op == OP_IRQ_EXIT ##2 stk_push [*1]);
  c_dec_skip: cover property (ex && op == OP_DEC_SKZ ##1 s_q.st == ST_DUMMY);
endmodule
`default_nettype wire

// >>> sim/acpu_mem_model.sv
// behavioural program memory, data memory and return stack beside the core
`timescale 1ns/1ps
`default_nettype none
`include "acpu_cfg.svh"
module acpu_mem_model (
  input  wire logic                  aclk,
  input  wire logic [`ACPU_PC_W-1:0] pm_addr,
  output logic [15:0]                pm_rdata,
  input  wire logic [7:0]            dm_addr,
  output logic [7:0]                 dm_rdata,
  input  wire logic [7:0]            dm_wdata,
  input  wire logic                  dm_we,
  output logic [`ACPU_PC_W-1:0]      stk_top,
  input  wire logic                  stk_pop,
  input  wire logic                  stk_push,
  input  wire logic [`ACPU_PC_W-1:0] stk_wdata
);
  // ----------
  // storage
  // ----------
  logic [15:0]           pm [0:2047];
  logic [7:0]            dm [0:255];
  logic [`ACPU_PC_W-1:0] stk [0:15];
  logic [3:0]            sp;
  // reads are combinational: the core samples them in the same cycle
  assign pm_rdata = pm[pm_addr];
  assign dm_rdata = dm[dm_addr];
  assign stk_top  = stk[sp - 4'h1];
  // pop and push never share an edge in this core, so no merge logic
  always @(posedge aclk) begin
    if (dm_we)
      dm[dm_addr] <= dm_wdata;
    if (stk_pop)
      sp <= sp - 4'h1;
    if (stk_push) begin
      stk[sp] <= stk_wdata;
      sp      <= sp + 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/test_accumulator_cpu_instr_subset.sv
// self-checking bench of the accumulator core against an integer model
`timescale 1ns/1ps
`default_nettype none
`include "acpu_cfg.svh"
module test_accumulator_cpu_instr_subset
  import acpu_pkg::*;
;
  logic        aclk, aresetn, irq_req, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [10:0] pm_addr, stk_top, stk_wdata;
  logic [15:0] pm_rdata;
  logic [7:0]  dm_addr, dm_rdata, dm_wdata;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic        dm_we, stk_pop, stk_push, awready, wready, bvalid, arready, rvalid;
  typedef struct {int a; int d; int c; int u;} acpu_exp_t;
  acpu_exp_t   eq[$];
  int          failures, checks_done, tclk, lclk, lcyc, haslast, n;
  int          acc, c, nib, z, wv, gie, pc, cyc, irq, unt, st[$], m[256];

  acpu_core i_dut (.aclk, .aresetn, .pm_addr, .pm_rdata, .dm_addr, .dm_rdata,
    .dm_wdata, .dm_we, .stk_top, .stk_pop, .stk_push, .stk_wdata, .irq_req,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);
  acpu_mem_model i_mem (.aclk, .pm_addr, .pm_rdata, .dm_addr, .dm_rdata,
    .dm_wdata, .dm_we, .stk_top, .stk_pop, .stk_push, .stk_wdata);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // ----------
  // helpers
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 50);
    rsp = bresp;
    bready <= 1'b0;
    if (k >= 50)
      failures++;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 50);
    rd  = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (k >= 50)
      failures++;
  endtask

  task automatic p(input int ad, input acpu_op_t op, input int arg);
    i_mem.pm[ad] = {op, arg[10:0]};
  endtask

  function automatic void mw(int a, int d);
    eq.push_back('{a, d, cyc, unt});
    m[a] = d;
    unt = 0;
  endfunction

  // ----------
  // reference model, one instruction per step, counting instruction cycles
  // ----------
  task automatic run_model();
    logic [15:0] w;
    int v, a, r, rl, rotate_left_through_carry, rr, rotate_right_through_carry, nb, d, done;
    done = 0;
    while (!done) begin
      if (gie && irq) begin
        st.push_back(pc);
        pc = 4;
        gie = 0;
        irq = 0;
        cyc++;
        unt = 1;
      end
      w = i_mem.pm[pc];
      a = w[7:0];
      v = m[a];
      rl = ((v << 1) | (v >> 7)) & 255;
      rotate_left_through_carry = ((v << 1) | c) & 255;
      rr = (v >> 1) | ((v & 1) << 7);
      rotate_right_through_carry = (v >> 1) | (c << 7);
      d = acc - v - (1 - c);
      nb = ((acc & 15) - (v & 15) - (1 - c)) < 0;
      r = d & 255;
      pc = (pc + 1) & 'h7ff;
      cyc++;
      case (w[15:11])
        OP_JUMP: begin
          done = (w[10:0] == pc - 1);
          pc = w[10:0];
          cyc++;
        end
        OP_LD_M: acc = v;
        OP_LD_I: acc = a;
        OP_ST_M: mw(a, acc);
        OP_OR_M, OP_OR_I: begin
          acc = acc | (w[11] ? v : a);
          z = (acc == 0);
        end
        OP_OR_TO_M: begin
          mw(a, acc | v);
          z = ((acc | v) == 0);
        end
        OP_SUB_EXIT: pc = st.pop_back();
        OP_SUB_EXIT_I: begin
          pc = st.pop_back();
          acc = a;
        end
        OP_IRQ_EXIT: begin
          pc = st.pop_back();
          gie = 1;
        end
        OP_ROTL_M: mw(a, rl);
        OP_ROTL_A: acc = rl;
        OP_ROTLC_M, OP_ROTLC_A: begin
          if (w[11]) mw(a, rotate_left_through_carry);
          else acc = rotate_left_through_carry;
          c = v >> 7;
        end
        OP_ROTR_M: mw(a, rr);
        OP_ROTR_A: acc = rr;
        OP_ROTRC_M, OP_ROTRC_A: begin
          if (w[11]) mw(a, rotate_right_through_carry);
          else acc = rotate_right_through_carry;
          c = v & 1;
        end
        OP_SUBB_A, OP_SUBB_M: begin
          wv = (((acc ^ v) & (acc ^ r) & 128) != 0);
          if (w[11]) acc = r;
          else mw(a, r);
          c = (d >= 0);
          z = (r == 0);
          nib = nb;
        end
        OP_DEC_SKZ: begin
          mw(a, (v - 1) & 255);
          if (v == 1) begin
            pc++;
            cyc++;
          end
        end
        default: ;
      endcase
    end
  endtask

  // ----------
  // write and stack monitor
  // ----------
  always @(posedge aclk) begin
    tclk++;
    if (aresetn === 1'b1 && dm_we === 1'b1) begin
      if (eq.size() == 0)
        chk("extra_write", 1, 0);
      else begin
        chk("write_addr", dm_addr, eq[0].a);
        chk("write_data", dm_wdata, eq[0].d);
        if (haslast && !eq[0].u)
          chk("write_gap", tclk - lclk, 3 * (eq[0].c - lcyc));
        haslast = 1;
        lclk = tclk;
        lcyc = eq[0].c;
        void'(eq.pop_front());
      end
    end
    if (stk_push === 1'b1)
      chk("irq_push", stk_wdata, 11'h060);
  end

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    print_verdict();
  end

  // ----------
  // main sequence
  // ----------
  initial begin
    aresetn = 1'b0;
    irq_req = 1'b1;
    irq = 1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 40'h0;
    wstrb = 4'hf;
    void'($urandom(95687));
    for (int i = 0; i < 256; i++)
      m[i] = $urandom_range(0, 255);
    m[8'h1d] = 1;
    m[8'h1e] = $urandom_range(2, 255);
    for (int i = 0; i < 256; i++)
      i_mem.dm[i] = m[i];
    p(0, OP_LD_I, $urandom_range(0, 255));
    p(1, OP_ST_M, 'h80);
    p(2, OP_OR_M, 'h10);
    p(3, OP_JUMP, 'h20);
    p(4, OP_ST_M, 'h81);
    p(5, OP_IRQ_EXIT, 0);
    p('h20, OP_OR_I, $urandom_range(0, 255));
    p('h21, OP_OR_TO_M, 'h11);
    p('h22, OP_LD_M, 'h12);
    for (int i = 0; i < 8; i++)
      p('h23 + i, acpu_op_t'(OP_ROTL_M + i), 'h13 + i);
    p('h2b, OP_SUBB_A, 'h1b);
    p('h2c, OP_SUBB_M, 'h1c);
    p('h2d, OP_ST_M, 'h82);
    p('h2e, OP_DEC_SKZ, 'h1d);
    p('h2f, OP_ST_M, 'h83);
    p('h30, OP_DEC_SKZ, 'h1e);
    p('h31, OP_IDLE, 0);
    p('h32, OP_SUB_EXIT, 0);
    p('h40, OP_ST_M, 'h84);
    p('h41, OP_SUB_EXIT_I, $urandom_range(0, 255));
    p('h50, OP_ST_M, 'h85);
    p('h51, OP_IRQ_EXIT, 0);
    p('h60, OP_ST_M, 'h86);
    p('h61, OP_JUMP, 'h61);
    st = '{'h60, 'h50, 'h40};
    for (int i = 0; i < 3; i++)
      i_mem.stk[i] = st[i];
    i_mem.sp = 4'h3;
    run_model();
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(`ACPU_CTRL_OFF);
    chk("ctrl_reset", rd, 1);
    axi_rd(4'hc);
    chk("rd_unmapped", rsp, `ACPU_RESP_SLV);
    axi_wr(4'hc, 0);
    chk("wr_unmapped", rsp, `ACPU_RESP_SLV);
    n = 0;
    while (eq.size() > 0 && n < 3000) begin
      @(posedge aclk);
      n++;
      // the request is served once, so it drops as soon as the push shows
      if (stk_push === 1'b1)
        irq_req <= 1'b0;
    end
    repeat (30) @(posedge aclk);
    chk("writes_left", eq.size(), 0);
    // lane 0 disabled: the run bit must keep its value
    wstrb <= 4'h0;
    axi_wr(`ACPU_CTRL_OFF, 0);
    wstrb <= 4'hf;
    axi_rd(`ACPU_CTRL_OFF);
    chk("ctrl_lane", rd, 1);
    axi_wr(`ACPU_CTRL_OFF, 0);
    repeat (10) @(posedge aclk);
    axi_rd(`ACPU_CTRL_OFF);
    chk("ctrl_run", rd, 0);
    axi_rd(`ACPU_PCR_OFF);
    chk("pc", rd, 'h61);
    axi_wr(`ACPU_STAT_OFF, 0);
    chk("ro_resp", rsp, `ACPU_RESP_OKAY);
    axi_rd(`ACPU_STAT_OFF);
    // flags that the bench checks nowhere else ride along in this one word
    n = (gie << 12) | (wv << 11) | (z << 10) | (nib << 9) | (c << 8) | acc;
    chk("status", rd, n);
    print_verdict();
  end
endmodule
`default_nettype wire
